/* rssd_map.vh */
// Purpose: Constants for the relay self-supervision block
// Assumes: Included by rssd_top.v
// Notes: Offsets are word indices on the plain register port
`ifndef RSSD_MAP_VH
`define RSSD_MAP_VH
`define RSSD_ADDR_W 4
`define RSSD_OFS_RELAY_DIAG 4'h0
`define RSSD_OFS_SECOND_DIAG 4'h1
`define RSSD_OFS_HEALTH_DIAG 4'h2
`define RSSD_OFS_COMM_DIAG 4'h3
`define RSSD_OFS_STATUS 4'h4
`define RSSD_OFS_CONTROL 4'h5
`define RSSD_OFS_EVENT 4'h6
`define RSSD_ST_BOOT 3'h0
`define RSSD_ST_RUN 3'h1
`define RSSD_ST_RESTART 3'h2
`define RSSD_ST_RECOVER 3'h3
`define RSSD_ST_PERM 3'h4
`define RSSD_EVT_ON 8'h38
`define RSSD_EVT_OFF 8'h39
`define RSSD_CTL_KICK 4'h0
`define RSSD_CTL_BOOT_OK 4'h1
`define RSSD_CTL_CLEAR 4'h2
`define RSSD_HEALTH_MASK 16'hffdf
`define RSSD_COMM_MASK 3'h6
`define RSSD_LVL_SUPPLY 0
`define RSSD_LVL_PANEL 1
`define RSSD_CNT_ZERO 32'h00000000
`define RSSD_WDG_TIMEOUT_US 1000
`define RSSD_RST_PULSE_US 10
`define RSSD_RECOVER_US 100000
`define RSSD_CLK_MHZ 200
`define RSSD_ZERO16 16'h0000
`endif

/* rssd_top.v */
// Purpose: Watchdog and self-diagnostic status logic of a protection relay
// Assumes: Host microcontroller kicks the watchdog and posts boot results over the register port
// Notes: One clock, no interrupts, all diagnostic words read-only
//
// How it works
// R1: On missed kicks the watchdog pulses the controller restart output.
// R2: A restart not followed by a kick raises the permanent fault output.
// R3: Permanent fault gates off every output relay but the status relay.
// R4: Status relay energized only while supply good and no permanent fault.
// R5: Internal rail faults feed health word and count as inoperative condition.
// R6: Boot check result gates entry to run; runtime faults are monitored continuously.
// R7: Permanent state drops status relay, lights LED, raises panel fault message.
// R8: Temporary fault onset sets matrix signal and posts the onset event code.
// R9: Temporary fault clearing posts the separate off event code.
// R10: Latched diagnostic state clears only by the local panel reset command.
// R11: Four 16-bit diagnostic words readable on the register port.
// R12: Relay word bits 0-3 trip relay faults, bit 4 alarm relay fault.
// R13: Health word bits 0-3 current loop, stack, memory, background timeout.
// R14: Health word bit 4 input, bit 6 arc card, bit 7 seconds tick.
// R15: Health bits 8 setting, 9 overload, 10-11 rails, 12 overheat.
// R16: Health bits 13-14 converter checks, bit 15 nonvolatile store.
// R17: Comm word bit 1 link buffer, bit 2 product code fault.
// R18: Event word carries code plus latched fault word for diagnostic view; offset 6 holds only the fault snapshot taken at onset, no code.
// R19: Undefined diagnostic bits read as zero.
//
// Implementation choices: the strobed register port and the address map.
`include "rssd_map.vh"
`timescale 1ns/1ps
`default_nettype none
module rssd_top #(
	parameter WDG_CYCLES = `RSSD_WDG_TIMEOUT_US * `RSSD_CLK_MHZ,
	parameter RST_CYCLES = `RSSD_RST_PULSE_US * `RSSD_CLK_MHZ,
	parameter RECOVER_CYCLES = `RSSD_RECOVER_US * `RSSD_CLK_MHZ,
	parameter RELAYS = 5
) (
	// Clock and reset
	input wire mclk_i,
	input wire rstn_i,
	// Register port
	input wire [`RSSD_ADDR_W-1:0] addr_i,
	input wire [15:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [15:0] rdata_o,
	// Fault sources (asynchronous pins)
	input wire [4:0] relay_fault_i,
	input wire [15:0] health_fault_i,
	input wire [2:0] comm_fault_i,
	input wire supply_ok_i,
	input wire panel_reset_i,
	// Relay requests from the controller
	input wire [RELAYS-1:0] relay_req_i,
	// Outputs
	output wire [RELAYS-1:0] relay_drive_o,
	output reg inoperative_status_relay_o,
	output reg status_led_o,
	output reg panel_fault_msg_o,
	output reg perm_fault_o,
	output reg mcu_restart_o,
	output reg selfdiag_signal_o,
	output reg event_valid_o,
	output reg [7:0] event_code_o
);
	// ***************
	// Reset synchroniser
	// ***************
	reg [1:0] rst_sync_q;
	wire rst_n;
	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	// Release waits two edges so no register leaves reset on a marginal edge
	assign rst_n = rst_sync_q[1];

	// ***************
	// Pin synchronisers
	// ***************
	// Second stage only is read; first stage feeds nothing else
	reg [13:0] hlo_s1_q;
	reg [13:0] hlo_s2_q;
	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			hlo_s1_q <= 14'h0000;
			hlo_s2_q <= 14'h0000;
		end else begin
			hlo_s1_q <= health_fault_i[13:0];
			hlo_s2_q <= hlo_s1_q;
		end
	end
	reg [4:0] rly_s1_q;
	reg [4:0] rly_s2_q;
	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			rly_s1_q <= 5'h00;
			rly_s2_q <= 5'h00;
		end else begin
			rly_s1_q <= relay_fault_i;
			rly_s2_q <= rly_s1_q;
		end
	end
	reg [2:0] com_s1_q;
	reg [2:0] com_s2_q;
	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			com_s1_q <= 3'h0;
			com_s2_q <= 3'h0;
		end else begin
			com_s1_q <= comm_fault_i;
			com_s2_q <= com_s1_q;
		end
	end
	// Supply and panel levels are slow; two flops are enough, no debounce
	reg [1:0] lvl_s1_q;
	reg [1:0] lvl_s2_q;
	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			lvl_s1_q <= 2'h0;
			lvl_s2_q <= 2'h0;
		end else begin
			lvl_s1_q <= {panel_reset_i, supply_ok_i};
			lvl_s2_q <= lvl_s1_q;
		end
	end
	reg [RELAYS-1:0] req_s1_q;
	reg [RELAYS-1:0] req_s2_q;
	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			req_s1_q <= {RELAYS{1'b0}};
			req_s2_q <= {RELAYS{1'b0}};
		end else begin
			req_s1_q <= relay_req_i;
			req_s2_q <= req_s1_q;
		end
	end
	reg [1:0] hs1_q;
	reg [1:0] hs2_q;
	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			hs1_q <= 2'h0;
			hs2_q <= 2'h0;
		end else begin
			hs1_q <= health_fault_i[15:14];
			hs2_q <= hs1_q;
		end
	end
	// Health bit 5 has no meaning and is forced to zero
	wire [15:0] health_now = {hs2_q, hlo_s2_q} & `RSSD_HEALTH_MASK; // [R13] [R14] [R15] [R16] [R19]
	wire [4:0] relay_now = rly_s2_q; // [R12]
	wire [2:0] comm_now = com_s2_q & `RSSD_COMM_MASK; // [R17] [R19]
	wire supply_ok = lvl_s2_q[`RSSD_LVL_SUPPLY];
	wire panel_reset = lvl_s2_q[`RSSD_LVL_PANEL];
	wire rail_fault = health_now[10] | health_now[11]; // [R5]
	wire any_fault = (|health_now) | (|relay_now) | (|comm_now); // [R6]

	// ***************
	// Watchdog state machine
	// ***************
	function [31:0] cnt_next;
		input [31:0] c;
		begin
			cnt_next = (c == `RSSD_CNT_ZERO) ? `RSSD_CNT_ZERO : c - 32'h1;
		end
	endfunction
	function cnt_done;
		input [31:0] c;
		begin
			cnt_done = (c == `RSSD_CNT_ZERO);
		end
	endfunction
	// Control word decode, shared by kick, boot result and clear
	function ctl_hit;
		input wr;
		input [`RSSD_ADDR_W-1:0] a;
		input [15:0] d;
		input [3:0] pos;
		begin
			ctl_hit = wr && (a == `RSSD_OFS_CONTROL) && d[pos];
		end
	endfunction
	wire kick = ctl_hit(wr_i, addr_i, wdata_i, `RSSD_CTL_KICK);
	wire boot_ok = ctl_hit(wr_i, addr_i, wdata_i, `RSSD_CTL_BOOT_OK);
	wire sw_clear = ctl_hit(wr_i, addr_i, wdata_i, `RSSD_CTL_CLEAR);
	reg [2:0] st_q;
	reg [2:0] st_d;
	reg [31:0] cnt_q;
	reg [31:0] cnt_d;
	reg restarted_q;
	reg restarted_d;
	always @* begin
		st_d = st_q;
		cnt_d = cnt_next(cnt_q);
		restarted_d = restarted_q;
		case (st_q)
			`RSSD_ST_BOOT: begin
				// Boot self-test must pass before supervision starts
				if (boot_ok && !any_fault) begin // [R6]
					st_d = `RSSD_ST_RUN;
					cnt_d = WDG_CYCLES;
				end
			end
			`RSSD_ST_RUN: begin
				if (kick) begin
					cnt_d = WDG_CYCLES;
					restarted_d = 1'b0;
				end else if (cnt_done(cnt_q)) begin
					if (restarted_q) begin
						st_d = `RSSD_ST_PERM; // [R2]
					end else begin
						st_d = `RSSD_ST_RESTART; // [R1]
						cnt_d = RST_CYCLES;
					end
				end
			end
			`RSSD_ST_RESTART: begin
				if (cnt_done(cnt_q)) begin
					st_d = `RSSD_ST_RECOVER;
					cnt_d = RECOVER_CYCLES;
					restarted_d = 1'b1;
				end
			end
			`RSSD_ST_RECOVER: begin
				// One restart until a kick in run re-arms it; a silent controller after it is permanent
				if (kick) begin
					st_d = `RSSD_ST_RUN;
					cnt_d = WDG_CYCLES;
				end else if (cnt_done(cnt_q)) begin
					st_d = `RSSD_ST_PERM; // [R2]
				end
			end
			`RSSD_ST_PERM: begin
				// Sticky until reset: only a power cycle or pin reset leaves it
				cnt_d = `RSSD_CNT_ZERO;
			end
			default: begin
				st_d = `RSSD_ST_BOOT;
			end
		endcase
	end
	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= `RSSD_ST_BOOT;
			cnt_q <= `RSSD_CNT_ZERO;
			restarted_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			restarted_q <= restarted_d;
		end
	end
	wire perm = (st_q == `RSSD_ST_PERM);

	// ***************
	// Relay outputs and panel indication
	// ***************
	// Blocking is combinational so no stale relay pulse escapes the fault
	assign relay_drive_o = perm ? {RELAYS{1'b0}} : req_s2_q; // [R3]
	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			inoperative_status_relay_o <= 1'b0;
			status_led_o <= 1'b0;
			panel_fault_msg_o <= 1'b0;
			perm_fault_o <= 1'b0;
			mcu_restart_o <= 1'b0;
		end else begin
			// Working-current principle: energized only when past boot with supply good, no rail fault and no permanent fault
			inoperative_status_relay_o <= supply_ok && !perm && !rail_fault && st_q != `RSSD_ST_BOOT; // [R4] [R5] [R7]
			status_led_o <= perm; // [R7]
			panel_fault_msg_o <= perm; // [R7]
			perm_fault_o <= perm; // [R2]
			mcu_restart_o <= (st_q == `RSSD_ST_RESTART); // [R1]
		end
	end

	// ***************
	// Temporary fault latch and events
	// ***************
	reg fault_prev_q;
	reg [15:0] latch_relay_q;
	reg [15:0] latch_health_q;
	reg [15:0] latch_comm_q;
	reg [15:0] ev_word_q;
	wire clear_req = panel_reset; // [R10]
	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			fault_prev_q <= 1'b0;
			selfdiag_signal_o <= 1'b0;
			event_valid_o <= 1'b0;
			event_code_o <= 8'h00;
			latch_relay_q <= `RSSD_ZERO16;
			latch_health_q <= `RSSD_ZERO16;
			latch_comm_q <= `RSSD_ZERO16;
			ev_word_q <= `RSSD_ZERO16;
		end else begin
			fault_prev_q <= any_fault;
			event_valid_o <= 1'b0;
			if (any_fault && !fault_prev_q) begin
				event_valid_o <= 1'b1;
				event_code_o <= `RSSD_EVT_ON; // [R8]
				ev_word_q <= health_now | {relay_now, 11'h000} | {comm_now, 13'h0000}; // [R18]
			end else if (!any_fault && fault_prev_q) begin
				event_valid_o <= 1'b1;
				event_code_o <= `RSSD_EVT_OFF; // [R9]
			end
			// New faults win over a same-cycle clear
			if (any_fault) begin
				selfdiag_signal_o <= 1'b1; // [R8]
			end else if (clear_req) begin
				selfdiag_signal_o <= 1'b0; // [R10]
			end
			latch_relay_q <= (clear_req ? `RSSD_ZERO16 : latch_relay_q) | {11'h000, relay_now}; // [R10] [R12]
			latch_health_q <= (clear_req ? `RSSD_ZERO16 : latch_health_q) | health_now; // [R10]
			latch_comm_q <= (clear_req ? `RSSD_ZERO16 : latch_comm_q) | {13'h0000, comm_now}; // [R10] [R17]
		end
	end
	wire unused_clear = sw_clear; // Remote clear clears nothing; it only shows in status word bit 5

	// ***************
	// Register read port
	// ***************
	// Read data is zero outside its slot so a bus OR of several slaves stays clean
	function [15:0] read_word;
		input [`RSSD_ADDR_W-1:0] a;
		input [15:0] relay_w;
		input [15:0] health_w;
		input [15:0] comm_w;
		input [15:0] status_w;
		input [15:0] event_w;
		begin
			case (a)
				`RSSD_OFS_RELAY_DIAG: read_word = relay_w; // [R11] [R19]
				`RSSD_OFS_SECOND_DIAG: read_word = `RSSD_ZERO16; // [R19]
				`RSSD_OFS_HEALTH_DIAG: read_word = health_w; // [R11]
				`RSSD_OFS_COMM_DIAG: read_word = comm_w; // [R11]
				`RSSD_OFS_STATUS: read_word = status_w;
				`RSSD_OFS_EVENT: read_word = event_w; // [R18]
				default: read_word = `RSSD_ZERO16;
			endcase
		end
	endfunction
	wire [15:0] status_word = {10'h000, unused_clear, selfdiag_signal_o, perm, st_q};
	reg [15:0] rdata_d;
	always @* begin
		rdata_d = `RSSD_ZERO16;
		if (rd_i) begin
			rdata_d = read_word(addr_i, latch_relay_q, latch_health_q, latch_comm_q, status_word, ev_word_q);
		end
	end
	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_o <= `RSSD_ZERO16;
		end else begin
			rdata_o <= rdata_d;
		end
	end
endmodule // rssd_top
`default_nettype wire

/* rssd_top_props.sv */
// Purpose: Port assertions for the self-supervision block
// Assumes: Bound to rssd_top; rstn_i is the raw pin
// Notes: Read data is checked only on its fixed positions
`timescale 1ns/1ps
`default_nettype none
module rssd_chk #(parameter RELAYS = 5) (
	// Watched ports
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic [3:0] addr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	input wire logic supply_ok_i,
	input wire logic [RELAYS-1:0] relay_drive_o,
	input wire logic inoperative_status_relay_o,
	input wire logic status_led_o,
	input wire logic panel_fault_msg_o,
	input wire logic perm_fault_o,
	input wire logic event_valid_o,
	input wire logic [7:0] event_code_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	property p_block; perm_fault_o |-> relay_drive_o == '0; endproperty
	a_block: assert property (p_block) else $error("relay driven while failed");
	property p_perm; perm_fault_o |-> !inoperative_status_relay_o && status_led_o && panel_fault_msg_o; endproperty
	a_perm: assert property (p_perm) else $error("failed state outputs");
	property p_stick; perm_fault_o |=> perm_fault_o; endproperty
	a_stick: assert property (p_stick) else $error("failed state left");
	property p_supply; $fell(supply_ok_i) |-> ##[1:4] !inoperative_status_relay_o; endproperty
	a_supply: assert property (p_supply) else $error("status relay held");
	property p_evt; event_valid_o |-> event_code_o == 8'h38 || event_code_o == 8'h39; endproperty
	a_evt: assert property (p_evt) else $error("bad event code");
	property p_idle; !$past(rd_i) |-> rdata_o == 16'h0000; endproperty
	a_idle: assert property (p_idle) else $error("read data outside slot");
	property p_zero; $past(rd_i) && $past(addr_i) == 4'h1 |-> rdata_o == 16'h0000; endproperty
	a_zero: assert property (p_zero) else $error("empty word not zero");
	property p_comm; $past(rd_i) && $past(addr_i) == 4'h3 |-> (rdata_o & 16'hfff9) == 16'h0000; endproperty
	a_comm: assert property (p_comm) else $error("comm word spare bits");
endmodule // rssd_chk
bind rssd_top rssd_chk #(.RELAYS(RELAYS)) u_rssd_chk (.mclk_i, .rstn_i, .addr_i, .rd_i, .rdata_o, .supply_ok_i,
	.relay_drive_o, .inoperative_status_relay_o, .status_led_o, .panel_fault_msg_o, .perm_fault_o, .event_valid_o,
	.event_code_o);
`default_nettype wire

/* rssd_mcu_model.sv */
// Purpose: Supervised controller model, sole writer of the control word
// Assumes: Bench keeps its reads off the write slot
// Notes: Boot result first, then a kick every 8 cycles while alive
`timescale 1ns/1ps
`default_nettype none
module rssd_mcu_model (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Bench control
	input wire logic alive_i,
	// Write side
	output logic wr_o,
	output logic [15:0] wdata_o,
	output logic [2:0] cnt_q
);
	logic up_q;
	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= 3'h1;
			wr_o <= 1'b0;
			up_q <= 1'b0;
			wdata_o <= 16'h0000;
		end else begin
			cnt_q <= cnt_q + 3'h1;
			wr_o <= alive_i && cnt_q == 3'h0;
			// Idle data toggles so a stale word is never mistaken for a write
			wdata_o <= (alive_i && cnt_q == 3'h0) ? (up_q ? 16'h0001 : 16'h0002) : ~wdata_o;
			up_q <= up_q | wr_o;
		end
	end
endmodule // rssd_mcu_model
`default_nettype wire

/* rssd_top_bench.sv */
// Purpose: Self-checking bench for the self-supervision block
// Assumes: Short watchdog counts set by parameter
// Notes: Reads and events are checked from queues by a monitor
`timescale 1ns/1ps
`default_nettype none
module rssd_top_bench;
	logic mclk_i = 0, rstn_i = 0, rd_i = 0, wr_i, supply_ok_i = 1, panel_reset_i = 0, alive_i = 1, rd_q = 0;
	logic [3:0] ba = 0, addr_i;
	logic [2:0] comm_fault_i = 0, cnt;
	logic [4:0] relay_fault_i = 0, relay_req_i = 0, relay_drive_o;
	logic [15:0] wdata_i, rdata_o, health_fault_i = 0, h, r;
	logic [15:0] rq[$], eq[$];
	logic inoperative_status_relay_o, status_led_o, panel_fault_msg_o, perm_fault_o;
	logic mcu_restart_o, selfdiag_signal_o, event_valid_o;
	logic [7:0] event_code_o;
	int n_errors = 0, compares = 0;
	rssd_top #(.WDG_CYCLES(20), .RST_CYCLES(4), .RECOVER_CYCLES(30)) u_rssd_top (.mclk_i, .rstn_i, .addr_i,
		.wdata_i, .wr_i, .rd_i, .rdata_o, .relay_fault_i, .health_fault_i, .comm_fault_i, .supply_ok_i,
		.panel_reset_i, .relay_req_i, .relay_drive_o, .inoperative_status_relay_o, .status_led_o,
		.panel_fault_msg_o, .perm_fault_o, .mcu_restart_o, .selfdiag_signal_o, .event_valid_o, .event_code_o);
	rssd_mcu_model u_rssd_mcu_model (.mclk_i, .rstn_i, .alive_i, .wr_o(wr_i), .wdata_o(wdata_i), .cnt_q(cnt));
	assign addr_i = wr_i ? 4'h5 : ba;
	initial forever #2.5 mclk_i = ~mclk_i;
	initial begin
		#15000;
		n_errors++;
		test_done;
	end
	task chk(input logic [15:0] s, e);
		compares++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Reads dodge the controller's write slot since both share the address
	task rd(input logic [3:0] a, input logic [15:0] e);
		do @(posedge mclk_i); while (cnt == 3'h0);
		rd_i <= 1'b1;
		ba <= a;
		rq.push_back(e);
		@(posedge mclk_i);
		rd_i <= 1'b0;
		ba <= ~a;
	endtask
	task wt(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	task test_done;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge mclk_i) begin
		rd_q <= rd_i;
		if (rd_q) chk(rdata_o, rq.pop_front());
		if (event_valid_o === 1'b1) chk({8'h00, event_code_o}, eq.size() ? eq.pop_front() : 16'hffff);
	end
	initial begin
		r = $urandom(32'h558e5fb8);
		wt(2);
		rstn_i <= 1'b1;
		wt(3);
		rd(4'h4, 16'h0000);
		chk(inoperative_status_relay_o, 16'h0);
		wt(30);
		chk(inoperative_status_relay_o, 16'h1);
		rd(4'h4, 16'h0001);
		r = ($urandom | 16'h0001) & 16'h001f;
		h = $urandom | 16'h0001;
		relay_fault_i <= r[4:0];
		health_fault_i <= h;
		comm_fault_i <= 3'h7;
		eq.push_back(16'h0038);
		wt(6);
		chk(selfdiag_signal_o, 16'h1);
		rd(4'h0, r);
		rd(4'h1, 16'h0000);
		rd(4'h2, h & 16'hffdf);
		rd(4'h3, 16'h0006);
		relay_fault_i <= 5'h00;
		health_fault_i <= 16'h0000;
		comm_fault_i <= 3'h0;
		eq.push_back(16'h0039);
		wt(6);
		rd(4'h2, h & 16'hffdf);
		panel_reset_i <= 1'b1;
		wt(5);
		panel_reset_i <= 1'b0;
		wt(3);
		chk(selfdiag_signal_o, 16'h0);
		rd(4'h0, 16'h0000);
		supply_ok_i <= 1'b0;
		wt(5);
		chk(inoperative_status_relay_o, 16'h0);
		supply_ok_i <= 1'b1;
		relay_req_i <= 5'h1f;
		wt(5);
		chk(relay_drive_o, 16'h001f);
		alive_i <= 1'b0;
		for (int i = 0; i < 60 && mcu_restart_o !== 1'b1; i++) @(posedge mclk_i);
		chk(mcu_restart_o, 16'h1);
		for (int i = 0; i < 80 && perm_fault_o !== 1'b1; i++) @(posedge mclk_i);
		wt(1);
		chk(relay_drive_o, 16'h0000);
		chk({inoperative_status_relay_o, status_led_o, panel_fault_msg_o}, 16'h3);
		rd(4'h4, 16'h000c);
		wt(2);
		chk(eq.size(), 16'h0);
		test_done;
	end
endmodule // rssd_top_bench
`default_nettype wire
